// file: logic/aperture_delay_pkg.sv
// How it works
// - Calibration done reads 1 only while enable is set and calibration finished.
// - Status field bits 16-0 return the delay word the calibration computed.
// - Clock invert bit set to 1 inverts the device sample clock.
// - Coarse field sets the aperture delay while calibration enable is 0.
// - Fine field adds a finer delay adjustment beside the coarse setting.
// - Ramp moves one code, or four with rate set, per 256 cycles.
// - Without ramping a coarse write reaches the output within 1024 cycles.
// - With ramping the delay steps until it equals the written coarse value.
// - A rising edge of calibration enable launches the calibration sequence.
// - While calibration enable is 1 the manual delay register is ignored.
package aperture_delay_pkg;

  // ----------------------------------------
  // Register indices; byte address is four times the index.
  // ----------------------------------------
  localparam logic [11:0] SYNC_CAL_ENABLE_IDX = 12'h2B0;
  localparam logic [11:0] SYNC_CAL_STATUS_IDX = 12'h2B2;
  localparam logic [11:0] APERTURE_DELAY_ADJUST_IDX = 12'h2B5;
  localparam logic [11:0] DELAY_RAMP_CONTROL_IDX = 12'h2B8;
  localparam int ADDR_W = 12;

  // ----------------------------------------
  // Field positions and reset values.
  // ----------------------------------------
  localparam int ENABLE_BIT = 0;
  localparam int DONE_BIT = 17;
  localparam int RESULT_W = 17;
  localparam int INVERT_BIT = 16;
  localparam int COARSE_LSB = 8;
  localparam int COARSE_W = 8;
  localparam int FINE_LSB = 0;
  localparam int FINE_W = 8;
  localparam int RAMP_EN_BIT = 0;
  localparam int RAMP_RATE_BIT = 1;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [23:0] ADJUST_RESET = 24'h000000;
  localparam logic [7:0] RAMP_RESET = 8'h00;

  // ----------------------------------------
  // Timing counts in device clock cycles, and ramp step sizes in codes.
  // ----------------------------------------
  localparam int RAMP_PERIOD_CYCLES = 256;
  localparam int ABRUPT_LIMIT_CYCLES = 1024;
  localparam logic [7:0] STEP_SLOW = 8'h01;
  localparam logic [7:0] STEP_FAST = 8'h04;

  // ----------------------------------------
  // Bus responses.
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: logic/coarse_ramp.sv
`timescale 1ns/10ps
module coarse_ramp #(
  parameter int W = 8,
  parameter int PERIOD = aperture_delay_pkg::RAMP_PERIOD_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Target and mode
  input wire logic [W-1:0] target,
  input wire logic ramp_en,
  input wire logic fast,
  // Applied value
  output logic [W-1:0] applied,
  output logic busy
);

  localparam int CW = $clog2(PERIOD);

  logic [W-1:0] applied_r;
  logic [CW-1:0] tick_r;
  logic [CW-1:0] tick_nxt;
  logic [W-1:0] step;
  logic [W-1:0] diff_up;
  logic [W-1:0] diff_dn;
  logic going_up;
  logic tick_end;
  logic [W-1:0] applied_nxt;

  // ----------------------------------------
  // Step selection.
  // ----------------------------------------
  // The step is clamped to the remaining distance so the ramp never overshoots.
  assign going_up = target > applied_r;
  assign diff_up = target - applied_r;
  assign diff_dn = applied_r - target;
  assign step = fast ? W'(aperture_delay_pkg::STEP_FAST) : W'(aperture_delay_pkg::STEP_SLOW);
  assign tick_end = tick_r == CW'(PERIOD - 1);
  assign busy = applied_r != target;
  assign tick_nxt = busy ? tick_r + CW'(1) : '0;

  // Target is read live, so a new write simply retargets the ramp.
  always_comb begin
    applied_nxt = applied_r;
    if (!ramp_en) begin
      applied_nxt = target;
    end else if (busy && tick_end) begin
      if (going_up) begin
        applied_nxt = (diff_up < step) ? target : applied_r + step;
      end else begin
        applied_nxt = (diff_dn < step) ? target : applied_r - step;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      applied_r <= '0;
      tick_r <= '0;
    end else begin
      applied_r <= applied_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign applied = applied_r;

endmodule

// file: logic/aperture_delay_adjust_ctrl.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module aperture_delay_adjust_ctrl #(
  parameter int RESULT_W = aperture_delay_pkg::RESULT_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [aperture_delay_pkg::ADDR_W+1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [aperture_delay_pkg::ADDR_W+1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Calibration engine
  output logic sync_cal_start,
  input wire logic sync_cal_complete,
  input wire logic [RESULT_W-1:0] sync_cal_delay_in,
  // Delay outputs
  output logic sample_clock_invert,
  output logic [aperture_delay_pkg::COARSE_W-1:0] coarse_delay,
  output logic [aperture_delay_pkg::FINE_W-1:0] fine_delay,
  output logic ramp_busy
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int AW = aperture_delay_pkg::ADDR_W;

  logic [7:0] enable_reg_r;
  logic [23:0] adjust_reg_r;
  logic [7:0] ramp_reg_r;
  logic [RESULT_W-1:0] result_r;
  logic finished_r;
  logic enable_prev_r;

  logic [AW-1:0] awidx_r;
  logic aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic sync_cal_enable;
  logic sync_cal_done;
  logic [23:0] sync_cal_status_reg;
  logic [7:0] coarse_applied;
  logic wr_fire;
  logic rd_fire;
  logic [AW-1:0] aridx;
  logic wr_hit_enable;
  logic wr_hit_adjust;
  logic wr_hit_ramp;
  logic wr_mapped;
  logic [31:0] rd_value;
  logic rd_mapped;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte-lane merge used for every writable register.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Word index from a byte address; low two bits are ignored.
  function automatic logic [AW-1:0] word_idx(input logic [AW+1:0] a);
    return a[AW+1:2];
  endfunction

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  // Address and data are caught independently; the response waits for both.
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign wr_hit_enable = awidx_r == aperture_delay_pkg::SYNC_CAL_ENABLE_IDX;
  assign wr_hit_adjust = awidx_r == aperture_delay_pkg::APERTURE_DELAY_ADJUST_IDX;
  assign wr_hit_ramp = awidx_r == aperture_delay_pkg::DELAY_RAMP_CONTROL_IDX;
  assign wr_mapped = wr_hit_enable || wr_hit_adjust || wr_hit_ramp;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      awidx_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      awidx_r <= word_idx(s_axi_awaddr);
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= aperture_delay_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? aperture_delay_pkg::RESP_OKAY : aperture_delay_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  // The status register is read-only; writes to it are answered with an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg_r <= aperture_delay_pkg::ENABLE_RESET;
      adjust_reg_r <= aperture_delay_pkg::ADJUST_RESET;
      ramp_reg_r <= aperture_delay_pkg::RAMP_RESET;
    end else if (wr_fire) begin
      if (wr_hit_enable) begin
        enable_reg_r <= 8'(merge(32'(enable_reg_r), wdata_r, wstrb_r));
      end
      if (wr_hit_adjust) begin
        adjust_reg_r <= 24'(merge(32'(adjust_reg_r), wdata_r, wstrb_r));
      end
      if (wr_hit_ramp) begin
        ramp_reg_r <= 8'(merge(32'(ramp_reg_r), wdata_r, wstrb_r));
      end
    end
  end

  // ----------------------------------------
  // Calibration control
  // ----------------------------------------
  assign sync_cal_enable = enable_reg_r[aperture_delay_pkg::ENABLE_BIT];
  assign sync_cal_start = sync_cal_enable && !enable_prev_r;

  // Completion in the launch cycle wins over the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_prev_r <= 1'b0;
      finished_r <= 1'b0;
      result_r <= '0;
    end else begin
      enable_prev_r <= sync_cal_enable;
      if (sync_cal_complete && sync_cal_enable) begin
        finished_r <= 1'b1;
        result_r <= sync_cal_delay_in;
      end else if (sync_cal_start) begin
        finished_r <= 1'b0;
      end
    end
  end

  assign sync_cal_done = sync_cal_enable && finished_r;
  assign sync_cal_status_reg = {6'h00, sync_cal_done, result_r};

  // ----------------------------------------
  // Coarse ramp
  // ----------------------------------------
  coarse_ramp #(
    .W(aperture_delay_pkg::COARSE_W),
    .PERIOD(aperture_delay_pkg::RAMP_PERIOD_CYCLES)
  ) u_ramp (
    .aclk(aclk),
    .aresetn(aresetn),
    .target(adjust_reg_r[aperture_delay_pkg::COARSE_LSB +: aperture_delay_pkg::COARSE_W]),
    .ramp_en(ramp_reg_r[aperture_delay_pkg::RAMP_EN_BIT]),
    .fast(ramp_reg_r[aperture_delay_pkg::RAMP_RATE_BIT]),
    .applied(coarse_applied),
    .busy(ramp_busy)
  );

  // ----------------------------------------
  // Delay outputs
  // ----------------------------------------
  // Outputs are registered so the delay line never sees a decode glitch.
  // With calibration enabled the calibrated word replaces the manual one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_clock_invert <= 1'b0;
      coarse_delay <= '0;
      fine_delay <= '0;
    end else if (sync_cal_enable) begin
      sample_clock_invert <= result_r[aperture_delay_pkg::INVERT_BIT];
      coarse_delay <= result_r[aperture_delay_pkg::COARSE_LSB +: aperture_delay_pkg::COARSE_W];
      fine_delay <= result_r[aperture_delay_pkg::FINE_LSB +: aperture_delay_pkg::FINE_W];
    end else begin
      sample_clock_invert <= adjust_reg_r[aperture_delay_pkg::INVERT_BIT];
      coarse_delay <= coarse_applied;
      fine_delay <= adjust_reg_r[aperture_delay_pkg::FINE_LSB +: aperture_delay_pkg::FINE_W];
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign aridx = word_idx(s_axi_araddr);
  assign s_axi_arready = !rvalid_r;
  assign rd_fire = s_axi_arvalid && !rvalid_r;

  always_comb begin
    rd_value = 32'h00000000;
    rd_mapped = 1'b1;
    unique case (aridx)
      aperture_delay_pkg::SYNC_CAL_ENABLE_IDX: rd_value = 32'(enable_reg_r);
      aperture_delay_pkg::SYNC_CAL_STATUS_IDX: rd_value = 32'(sync_cal_status_reg);
      aperture_delay_pkg::APERTURE_DELAY_ADJUST_IDX: rd_value = 32'(adjust_reg_r);
      aperture_delay_pkg::DELAY_RAMP_CONTROL_IDX: rd_value = 32'(ramp_reg_r);
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= aperture_delay_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_value;
      rresp_r <= rd_mapped ? aperture_delay_pkg::RESP_OKAY : aperture_delay_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule

// file: bench/aperture_delay_monitor.sv
`timescale 1ns/10ps
module aperture_delay_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [aperture_delay_pkg::ADDR_W+1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Delay side
  input wire logic sync_cal_start,
  input wire logic ramp_busy
);
  wire [11:0] rd_idx = s_axi_araddr[13:2];
  wire rd_mapped = rd_idx == aperture_delay_pkg::SYNC_CAL_ENABLE_IDX || rd_idx == aperture_delay_pkg::SYNC_CAL_STATUS_IDX
    || rd_idx == aperture_delay_pkg::APERTURE_DELAY_ADJUST_IDX || rd_idx == aperture_delay_pkg::DELAY_RAMP_CONTROL_IDX;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire w_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  start_pulse_a: assert property (sync_cal_start |=> !sync_cal_start)
    else $error("calibration start held longer than one cycle");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before acceptance");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before acceptance");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  rd_answer_a: assert property (ar_take |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  unmapped_rd_a: assert property (ar_take && !rd_mapped |=> s_axi_rresp == aperture_delay_pkg::RESP_SLVERR
    && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  cover property (sync_cal_start);
  cover property (s_axi_bvalid && s_axi_bresp == aperture_delay_pkg::RESP_SLVERR);
  cover property ($fell(ramp_busy));
endmodule

// file: bench/tb_aperture_delay_adjust_ctrl.sv
`timescale 1ns/10ps
module tb_aperture_delay_adjust_ctrl;
  localparam logic [13:0] A_EN = {aperture_delay_pkg::SYNC_CAL_ENABLE_IDX, 2'h0};
  localparam logic [13:0] A_ST = {aperture_delay_pkg::SYNC_CAL_STATUS_IDX, 2'h0};
  localparam logic [13:0] A_ADJ = {aperture_delay_pkg::APERTURE_DELAY_ADJUST_IDX, 2'h0};
  localparam logic [13:0] A_RMP = {aperture_delay_pkg::DELAY_RAMP_CONTROL_IDX, 2'h0};
  localparam logic [1:0] OK = aperture_delay_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = aperture_delay_pkg::RESP_SLVERR;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic sync_cal_start, sync_cal_complete, sample_clock_invert, ramp_busy;
  logic [16:0] sync_cal_delay_in;
  logic [7:0] coarse_delay, fine_delay;
  int bad_count, compares;
  aperture_delay_adjust_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sync_cal_start, .sync_cal_complete, .sync_cal_delay_in, .sample_clock_invert, .coarse_delay,
    .fine_delay, .ramp_busy);
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic summarize();
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w;
    aw = 0;
    w = 0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w) && n < 50);
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    bound(n, 50);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    bound(n, 50);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic wait_out(input logic [16:0] v, input int lim);
    int n;
    n = 0;
    while ({sample_clock_invert, coarse_delay, fine_delay} !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
    bound(n, lim);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic ramp_run(input logic [7:0] t, input int step);
    int n, gap, k, d;
    logic [7:0] p;
    n = 0;
    gap = 0;
    k = 0;
    p = coarse_delay;
    while (coarse_delay !== t && n < 3000) begin
      @(posedge aclk);
      n++;
      gap++;
      if (coarse_delay !== p) begin
        d = (t > p) ? t - p : p - t;
        if (d > step) d = step;
        chk("ramp step", {24'h0, coarse_delay}, {24'h0, (t > p) ? p + d[7:0] : p - d[7:0]});
        if (k > 0) chk("ramp gap", gap, 256);
        k++;
        gap = 0;
        p = coarse_delay;
      end
    end
    bound(n, 3000);
    repeat (600) @(posedge aclk);
    chk("ramp end", {24'h0, coarse_delay}, {24'h0, t});
    chk("ramp busy", {31'h0, ramp_busy}, 32'h0);
  endtask
  task automatic reset_values();
    rd(A_ADJ, 32'h0, OK);
    rd(A_RMP, 32'h0, OK);
    rd(A_ST, 32'h0, OK);
    rd(14'hAC4, 32'h0, ERR);
    wr(A_ST, 32'h0003FFFF, ERR);
    rd(A_ST, 32'h0, OK);
  endtask
  task automatic manual_set();
    wr(A_ADJ, 32'hFFFF357A, OK);
    wait_out(17'h1357A, 1024);
    chk("outputs", {15'h0, sample_clock_invert, coarse_delay, fine_delay}, 32'h0001357A);
    rd(A_ADJ, 32'h00FF357A, OK);
    wr(A_ADJ, 32'h0001367A, OK);
    wait_out(17'h1367A, 1024);
  endtask
  task automatic ramps();
    int n;
    wr(A_RMP, 32'h1, OK);
    wr(A_ADJ, 32'h0001387A, OK);
    ramp_run(8'h38, 1);
    wr(A_RMP, 32'h3, OK);
    wr(A_ADJ, 32'h00012F7A, OK);
    ramp_run(8'h2F, 4);
    wr(A_ADJ, 32'h0001507A, OK);
    n = 0;
    while (coarse_delay === 8'h2F && n < 300) begin
      @(posedge aclk);
      n++;
    end
    bound(n, 300);
    wr(A_ADJ, 32'h0001307A, OK);
    ramp_run(8'h30, 4);
    wr(A_RMP, 32'h0, OK);
  endtask
  task automatic calibrate();
    int n;
    n = 0;
    sync_cal_delay_in <= 17'h1A5C3;
    wr(A_EN, 32'h1, OK);
    while (sync_cal_start !== 1'b1 && n < 10) begin
      @(posedge aclk);
      n++;
    end
    bound(n, 10);
    rd(A_ST, 32'h0, OK);
    sync_cal_complete <= 1'b1;
    @(posedge aclk);
    sync_cal_complete <= 1'b0;
    rd(A_ST, 32'h0003A5C3, OK);
    wait_out(17'h1A5C3, 10);
    wr(A_ADJ, 32'h0, OK);
    repeat (20) @(posedge aclk);
    chk("cal hold", {15'h0, sample_clock_invert, coarse_delay, fine_delay}, 32'h0001A5C3);
    wr(A_EN, 32'h0, OK);
    rd(A_ST, 32'h0001A5C3, OK);
    wait_out(17'h0, 1024);
  endtask
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    bad_count = 0;
    compares = 0;
    aresetn = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 14'h0;
    s_axi_araddr = 14'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    sync_cal_complete = 0;
    sync_cal_delay_in = 17'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    reset_values();
    manual_set();
    ramps();
    calibrate();
    summarize();
  end
endmodule
bind aperture_delay_adjust_ctrl aperture_delay_monitor i_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sync_cal_start, .ramp_busy);
